//--- pkg/mlc_pkg.sv
// Constants and types shared by the lane configuration register bank.
// Assumes a single 25 MHz clock domain and byte-wide management accesses.
package mlc_pkg;

    // Clock and receiver-detect timing
    localparam int CLK_HZ = 25_000_000;
    localparam int DETECT_INTERVAL_MS = 12;
    localparam int DETECT_INTERVAL_CYC = CLK_HZ / 1000 * DETECT_INTERVAL_MS;
    localparam int DETECT_WINDOW_MS = 600;
    localparam int DETECT_MAX_TRIES = DETECT_WINDOW_MS / DETECT_INTERVAL_MS;
    localparam int DETECT_CNT_W = 20;
    localparam int DETECT_TRY_W = 6;

    // Register offsets
    localparam logic [7:0] OFS_SPARE_2F = 8'h2f;
    localparam logic [7:0] OFS_SPARE_32 = 8'h32;
    localparam logic [7:0] OFS_SPARE_33 = 8'h33;
    localparam logic [7:0] OFS_SWING = 8'h34;
    localparam logic [7:0] OFS_DEEMPH = 8'h35;
    localparam logic [7:0] OFS_SPARE_36 = 8'h36;
    localparam logic [7:0] OFS_RECEIVER_DETECT = 8'h39;

    // Reset values
    localparam logic [7:0] RST_SPARE_2F = 8'h00;
    localparam logic [7:0] RST_SPARE_32 = 8'h00;
    localparam logic [7:0] RST_SPARE_33 = 8'h2f;
    localparam logic [7:0] RST_SWING = 8'had;
    localparam logic [4:0] RST_DEEMPH_CTL = 5'h02;
    localparam logic [7:0] RST_SPARE_36 = 8'h00;
    localparam logic [7:0] RST_RECEIVER_DETECT = 8'h00;

    // Field positions
    localparam int SWING_SCP_BIT = 7;
    localparam int SWING_MODE_BIT = 6;
    localparam int RECEIVER_DETECT_FIELD_LSB = 2;

    // Mode status encodings; gen3 reads as zero so the reset mode bit gives 0x02
    localparam logic [1:0] MODE_STAT_GEN12 = 2'h1;
    localparam logic [1:0] MODE_STAT_GEN3 = 2'h0;

    // Default management slave address, value is arbitrary
    localparam logic [6:0] DEF_SLAVE_ADDR = 7'h5a;

    typedef enum logic [1:0] {
        MLC_RXD_HIGHZ = 2'b00,
        MLC_RXD_AUTO_LIMITED = 2'b01,
        MLC_RXD_AUTO_FOREVER = 2'b10,
        MLC_RXD_FORCE_50 = 2'b11
    } mlc_rxd_mode_t;

    typedef enum logic [2:0] {
        MLC_SM_IDLE = 3'b000,
        MLC_SM_ADDR = 3'b001,
        MLC_SM_ADDR_ACK = 3'b010,
        MLC_SM_WRITE = 3'b011,
        MLC_SM_WRITE_ACK = 3'b100,
        MLC_SM_READ = 3'b101,
        MLC_SM_READ_ACK = 3'b110
    } mlc_sm_state_t;

endpackage : mlc_pkg

//--- core/mlc_rx_detect.sv
// Receiver-detect sequencer for one input lane: periodic probe and termination.
// Assumes the analog detector answers on rx_present in the cycle the probe is high.
`timescale 1ns/1ns
module mlc_rx_detect
    import mlc_pkg::*;
#(
    parameter int INTERVAL_CYC = DETECT_INTERVAL_CYC
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [1:0] mode,
    input wire logic restart,
    input wire logic rx_present,
    output logic probe,
    output logic detected,
    output logic term_50ohm
);

    typedef struct packed {
        logic [DETECT_CNT_W-1:0] cnt;
        logic [DETECT_TRY_W-1:0] tries;
        logic probe;
        logic detected;
        logic term;
    } mlc_det_state_t;

    localparam logic [DETECT_CNT_W-1:0] CNT_LAST = DETECT_CNT_W'(INTERVAL_CYC - 1);
    localparam logic [DETECT_TRY_W-1:0] TRY_LIMIT = DETECT_TRY_W'(DETECT_MAX_TRIES);

    mlc_det_state_t st_reg;
    mlc_det_state_t st_next;

    // Probe scheduling; a rewrite of the mode field starts the sequence afresh
    always_comb
    begin
        st_next = st_reg;
        st_next.probe = 1'b0;
        if (st_reg.probe && rx_present)
        begin
            st_next.detected = 1'b1;
        end
        if (restart)
        begin
            st_next.cnt = '0;
            st_next.tries = '0;
            // A hit in the same cycle as a rewrite is kept when the new field selects 01 or 10, cleared otherwise
            st_next.detected = st_reg.probe && rx_present
                && (mode == MLC_RXD_AUTO_LIMITED || mode == MLC_RXD_AUTO_FOREVER);
        end
        else
        begin
            unique case (mlc_rxd_mode_t'(mode))
                MLC_RXD_HIGHZ:
                begin
                    st_next.cnt = '0;
                    st_next.detected = 1'b0;
                end
                MLC_RXD_FORCE_50:
                begin
                    st_next.cnt = '0;
                end
                MLC_RXD_AUTO_LIMITED, MLC_RXD_AUTO_FOREVER:
                begin
                    // Probing stops once a receiver is found or the tries run out
                    if (!st_reg.detected && !(st_reg.probe && rx_present))
                    begin
                        if (st_reg.cnt == CNT_LAST)
                        begin
                            st_next.cnt = '0;
                            if (mode == MLC_RXD_AUTO_FOREVER)
                            begin
                                st_next.probe = 1'b1;
                            end
                            else if (st_reg.tries < TRY_LIMIT)
                            begin
                                st_next.probe = 1'b1;
                                st_next.tries = st_reg.tries + 1'b1;
                            end
                        end
                        else
                        begin
                            st_next.cnt = st_reg.cnt + 1'b1;
                        end
                    end
                end
            endcase
        end
        // Termination: high-z until found, forced 50 ohm in mode 11
        st_next.term = (mode == MLC_RXD_FORCE_50)
            || ((mode == MLC_RXD_AUTO_LIMITED || mode == MLC_RXD_AUTO_FOREVER)
                && st_next.detected);
        if (mode == MLC_RXD_HIGHZ)
        begin
            st_next.term = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign probe = st_reg.probe;
    assign detected = st_reg.detected;
    assign term_50ohm = st_reg.term;

endmodule : mlc_rx_detect

//--- core/mlc_lane_regs.sv
// Lane configuration register bank behind a byte-wide two-wire management slave.
// Assumes scl and sda are already synchronous to clk; sda is open-drain.
//
// What this block does
// - Swing bit 7 enables short-circuit protection; reset 0xAD
// - Swing bit 6 selects rate mode, overrides pin
// - Swing bits 2:0 select amplitude 0.6-1.3 V
// - De-emphasis bit 7 shows receiver detected; reset 0x02
// - De-emphasis bits 6:5 show effective rate mode
// - De-emphasis bits 2:0 select de-emphasis level
// - Detect field 00 holds termination high impedance
// - Field 01 probes every 12 ms, 50 tries
// - Field 10 probes every 12 ms until detection
// - Field 11 forces 50 ohm termination immediately
// - Lane detect field beats global override control
// - Byte-wide access, host master, device slave
`timescale 1ns/1ns
module mlc_lane_regs
    import mlc_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = DEF_SLAVE_ADDR,
    parameter int DETECT_CYC = DETECT_INTERVAL_CYC
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic rx_present,
    output logic detect_probe,
    output logic term_50ohm,
    output logic short_circuit_prot_en,
    output logic rate_gen12_sel,
    output logic [2:0] output_swing_sel,
    output logic [2:0] deemphasis_sel
);

    typedef struct packed {
        logic scl_q;
        logic sda_q;
        mlc_sm_state_t sm;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic rw;
        logic ptr_pending;
        logic [7:0] ptr;
        logic oe;
        logic restart;
        logic [7:0] spare_2f;
        logic [7:0] spare_32;
        logic [7:0] spare_33;
        logic [7:0] swing;
        logic [4:0] deemph_ctl;
        logic [7:0] spare_36;
        logic [7:0] receiver_detect;
    } mlc_regs_state_t;

    localparam mlc_regs_state_t ST_RESET = '{
        scl_q: 1'b1, sda_q: 1'b1, sm: MLC_SM_IDLE, bitcnt: 3'h0, shreg: 8'h00,
        rw: 1'b0, ptr_pending: 1'b0, ptr: 8'h00, oe: 1'b0, restart: 1'b0,
        spare_2f: RST_SPARE_2F, spare_32: RST_SPARE_32, spare_33: RST_SPARE_33,
        swing: RST_SWING, deemph_ctl: RST_DEEMPH_CTL, spare_36: RST_SPARE_36,
        receiver_detect: RST_RECEIVER_DETECT
    };

    mlc_regs_state_t st_reg;
    mlc_regs_state_t st_next;
    logic det_found;
    logic [1:0] mode_status;
    logic [7:0] rd_data;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] rx_byte;

    // Receiver-detect sequencer; only the lane field steers it, so it wins
    mlc_rx_detect #(
        .INTERVAL_CYC(DETECT_CYC)
    ) u_rx_detect (
        .clk(clk),
        .arst_n(arst_n),
        .mode(st_reg.receiver_detect[RECEIVER_DETECT_FIELD_LSB +: 2]),
        .restart(st_reg.restart),
        .rx_present(rx_present),
        .probe(detect_probe),
        .detected(det_found),
        .term_50ohm(term_50ohm)
    );

    // Mode status follows the lane's own override bit, always in force
    assign mode_status = st_reg.swing[SWING_MODE_BIT] ? MODE_STAT_GEN12
        : MODE_STAT_GEN3;

    // Read mux; unmapped offsets read as zero
    always_comb
    begin
        unique case (st_reg.ptr)
            OFS_SPARE_2F: rd_data = st_reg.spare_2f;
            OFS_SPARE_32: rd_data = st_reg.spare_32;
            OFS_SPARE_33: rd_data = st_reg.spare_33;
            OFS_SWING: rd_data = st_reg.swing;
            OFS_DEEMPH: rd_data = {det_found, mode_status, st_reg.deemph_ctl};
            OFS_SPARE_36: rd_data = st_reg.spare_36;
            OFS_RECEIVER_DETECT: rd_data = st_reg.receiver_detect;
            default: rd_data = 8'h00;
        endcase
    end

    // Bus conditions seen on the sampled pins
    assign scl_rise = scl_in && !st_reg.scl_q;
    assign scl_fall = !scl_in && st_reg.scl_q;
    assign bus_start = scl_in && st_reg.scl_q && st_reg.sda_q && !sda_in;
    assign bus_stop = scl_in && st_reg.scl_q && !st_reg.sda_q && sda_in;
    assign rx_byte = {st_reg.shreg[6:0], sda_in};

    // Slave state machine and register writes, one byte per location
    always_comb
    begin
        st_next = st_reg;
        st_next.scl_q = scl_in;
        st_next.sda_q = sda_in;
        st_next.restart = 1'b0;
        if (bus_start)
        begin
            st_next.sm = MLC_SM_ADDR;
            st_next.bitcnt = 3'h0;
            st_next.oe = 1'b0;
        end
        else if (bus_stop)
        begin
            st_next.sm = MLC_SM_IDLE;
            st_next.oe = 1'b0;
        end
        else
        begin
            unique case (st_reg.sm)
                MLC_SM_IDLE:
                begin
                    st_next.oe = 1'b0;
                end
                MLC_SM_ADDR:
                begin
                    if (scl_rise)
                    begin
                        st_next.shreg = rx_byte;
                        st_next.bitcnt = st_reg.bitcnt + 3'h1;
                        if (st_reg.bitcnt == 3'h7)
                        begin
                            // Foreign addresses are left alone until the next start
                            st_next.rw = sda_in;
                            st_next.sm = (st_reg.shreg[6:0] == SLAVE_ADDR)
                                ? MLC_SM_ADDR_ACK : MLC_SM_IDLE;
                        end
                    end
                end
                MLC_SM_ADDR_ACK:
                begin
                    // First falling edge pulls sda low; second releases it for a write or drives data bit 7 for a read
                    if (scl_fall && !st_reg.oe)
                    begin
                        st_next.oe = 1'b1;
                    end
                    else if (scl_fall)
                    begin
                        st_next.bitcnt = 3'h0;
                        if (st_reg.rw)
                        begin
                            st_next.sm = MLC_SM_READ;
                            st_next.shreg = rd_data;
                            st_next.oe = !rd_data[7];
                        end
                        else
                        begin
                            st_next.sm = MLC_SM_WRITE;
                            st_next.ptr_pending = 1'b1;
                            st_next.oe = 1'b0;
                        end
                    end
                end
                MLC_SM_WRITE:
                begin
                    if (scl_rise)
                    begin
                        st_next.shreg = rx_byte;
                        st_next.bitcnt = st_reg.bitcnt + 3'h1;
                        if (st_reg.bitcnt == 3'h7)
                        begin
                            st_next.sm = MLC_SM_WRITE_ACK;
                            if (st_reg.ptr_pending)
                            begin
                                st_next.ptr = rx_byte;
                                st_next.ptr_pending = 1'b0;
                            end
                            else
                            begin
                                // Reserved bits are stored as written; the host keeps them
                                unique case (st_reg.ptr)
                                    OFS_SPARE_2F: st_next.spare_2f = rx_byte;
                                    OFS_SPARE_32: st_next.spare_32 = rx_byte;
                                    OFS_SPARE_33: st_next.spare_33 = rx_byte;
                                    OFS_SWING: st_next.swing = rx_byte;
                                    OFS_DEEMPH: st_next.deemph_ctl = rx_byte[4:0];
                                    OFS_SPARE_36: st_next.spare_36 = rx_byte;
                                    OFS_RECEIVER_DETECT:
                                    begin
                                        st_next.receiver_detect = rx_byte;
                                        st_next.restart = 1'b1;
                                    end
                                    default: st_next.shreg = rx_byte;
                                endcase
                                st_next.ptr = st_reg.ptr + 8'h01;
                            end
                        end
                    end
                end
                MLC_SM_WRITE_ACK:
                begin
                    if (scl_fall && !st_reg.oe)
                    begin
                        st_next.oe = 1'b1;
                    end
                    else if (scl_fall)
                    begin
                        st_next.oe = 1'b0;
                        st_next.bitcnt = 3'h0;
                        st_next.sm = MLC_SM_WRITE;
                    end
                end
                MLC_SM_READ:
                begin
                    // Data changes only while scl is low
                    if (scl_fall)
                    begin
                        if (st_reg.bitcnt == 3'h7)
                        begin
                            st_next.oe = 1'b0;
                            st_next.sm = MLC_SM_READ_ACK;
                        end
                        else
                        begin
                            st_next.shreg = {st_reg.shreg[6:0], 1'b0};
                            st_next.oe = !st_reg.shreg[6];
                            st_next.bitcnt = st_reg.bitcnt + 3'h1;
                        end
                    end
                end
                MLC_SM_READ_ACK:
                begin
                    if (scl_rise && sda_in)
                    begin
                        st_next.sm = MLC_SM_IDLE; // Host NACK ends the read
                    end
                    else if (scl_rise)
                    begin
                        st_next.ptr = st_reg.ptr + 8'h01;
                    end
                    else if (scl_fall)
                    begin
                        st_next.sm = MLC_SM_READ;
                        st_next.bitcnt = 3'h0;
                        st_next.shreg = rd_data;
                        st_next.oe = !rd_data[7];
                    end
                end
                default:
                begin
                    st_next.sm = MLC_SM_IDLE;
                    st_next.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= ST_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Analog controls come straight from the stored fields
    assign sda_out = 1'b0; // Open drain: only ever pulls low
    assign sda_oe = st_reg.oe;
    assign short_circuit_prot_en = st_reg.swing[SWING_SCP_BIT];
    assign rate_gen12_sel = st_reg.swing[SWING_MODE_BIT];
    assign output_swing_sel = st_reg.swing[2:0];
    assign deemphasis_sel = st_reg.deemph_ctl[2:0];

endmodule : mlc_lane_regs

//--- tb/mlc_lane_regs_assertions.sv
// Port checks for the lane register bank, bound into every instance.
// Assumes one clock domain and the detect interval of the bound design.
`timescale 1ns/1ns
module mlc_lane_regs_assertions
    import mlc_pkg::*;
#(
    parameter int DETECT_CYC = DETECT_INTERVAL_CYC
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic rx_present,
    input wire logic detect_probe,
    input wire logic term_50ohm,
    input wire logic short_circuit_prot_en,
    input wire logic rate_gen12_sel,
    input wire logic [2:0] output_swing_sel,
    input wire logic [2:0] deemphasis_sel
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic [19:0] gap_reg;
    logic [19:0] gap_next;

    // Cycles since the last probe; saturates so a long idle never wraps
    always_comb
    begin
        gap_next = (gap_reg == 20'hfffff) ? gap_reg : gap_reg + 20'h1;
        if (detect_probe)
            gap_next = 20'h1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            gap_reg <= 20'hfffff;
        else
            gap_reg <= gap_next;
    end

    // A probe that finds a receiver
    sequence s_hit;
        detect_probe && rx_present;
    endsequence

    // Bus clock high lately; writes land a cycle or two after the eighth rise
    sequence s_bus_recent;
        scl_in || $past(scl_in) || $past(scl_in, 2);
    endsequence

    a_oe_low_only: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data changed with clock high");
    a_oe_after_fall: assert property ($rose(sda_oe)
        |-> $past(scl_in, 2) && !$past(scl_in))
        else $error("data line pulled without a clock fall");
    a_probe_pulse: assert property (detect_probe |=> !detect_probe)
        else $error("probe too long");
    a_probe_gap: assert property (detect_probe |-> gap_reg >= 20'(DETECT_CYC))
        else $error("probes too close");
    a_detect_term: assert property (s_hit |=> term_50ohm)
        else $error("detection ignored");
    a_term_quiet: assert property (term_50ohm |-> !detect_probe)
        else $error("probe with termination on");
    a_cfg_on_bus: assert property ($changed({short_circuit_prot_en, rate_gen12_sel,
        output_swing_sel, deemphasis_sel}) |-> s_bus_recent)
        else $error("setting changed without a write");
    a_term_rise: assert property ($rose(term_50ohm) |-> $past(detect_probe) && $past(rx_present)
        || $past(scl_in) || $past(scl_in, 2))
        else $error("termination on without cause");
    a_term_fall: assert property ($fell(term_50ohm) |-> s_bus_recent)
        else $error("termination dropped without a write");
endmodule : mlc_lane_regs_assertions

bind mlc_lane_regs mlc_lane_regs_assertions #(.DETECT_CYC(DETECT_CYC)) i_mlc_lane_regs_assertions (
    .clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .rx_present(rx_present), .detect_probe(detect_probe),
    .term_50ohm(term_50ohm), .short_circuit_prot_en(short_circuit_prot_en),
    .rate_gen12_sel(rate_gen12_sel), .output_swing_sel(output_swing_sel),
    .deemphasis_sel(deemphasis_sel)
);

//--- tb/mlc_host_model.sv
// Management bus host: byte-wide register writes and reads.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns
module mlc_host_model
(
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // Idle bus: both lines released
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Data moves one edge after scl falls; scl low four clocks, high three
    task automatic bit_io(input logic b, output logic r);
        @(posedge clk);
        sda_low <= !b;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (3) @(posedge clk);
        r = sda;
        scl <= 1'b0;
    endtask : bit_io

    // Start is cond(0,1,0), stop is cond(1,0,1): data flips while scl high
    task automatic cond(input logic pre, input logic post, input logic scl_end);
        @(posedge clk);
        sda_low <= pre;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (3) @(posedge clk);
        sda_low <= post;
        repeat (3) @(posedge clk);
        scl <= scl_end;
    endtask : cond

    // MSB first; ack high when the device pulled the ninth bit low
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : send_byte

    // ok only when all three bytes were acknowledged
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
        input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        cond(1'b0, 1'b1, 1'b0);
        send_byte({dev, 1'b0}, a0);
        send_byte(ofs, a1);
        send_byte(d, a2);
        cond(1'b1, 1'b0, 1'b1);
        ok = a0 & a1 & a2;
    endtask : write_reg

    // Repeated start, one byte back, closed with a not-acknowledge
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d);
        logic a;
        cond(1'b0, 1'b1, 1'b0);
        send_byte({dev, 1'b0}, a);
        send_byte(ofs, a);
        cond(1'b0, 1'b1, 1'b0);
        send_byte({dev, 1'b1}, a);
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(1'b1, a);
        cond(1'b1, 1'b0, 1'b1);
    endtask : read_reg
endmodule : mlc_host_model

//--- tb/mlc_lane_regs_tb.sv
// Self-checking bench for the lane register bank: register map and detect sequencer.
// Assumes the host model owns the bus and the bench plays the far-end receiver.
`timescale 1ns/1ns
module mlc_lane_regs_tb
    import mlc_pkg::*;
;
    localparam int DET = 40; // Short interval keeps 50-probe runs brief
    localparam logic [6:0] SA = DEF_SLAVE_ADDR;
    localparam logic [7:0] OFS_TAB [8] = '{8'h2f, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h39, 8'h37};
    localparam logic [7:0] RST_TAB [8] = '{8'h00, 8'h00, 8'h2f, 8'had, 8'h02, 8'h00, 8'h00, 8'h00};
    logic clk, arst_n, rx_present, scl, sda_low, sda, sda_out, sda_oe, probe, term, scp, gen12, ok;
    logic [2:0] swing, deemph, c;
    logic [7:0] rd, sw;
    int fails, total_checks, probe_cnt, p0;

    // Pull-up wire: low while either side pulls it
    assign sda = !(sda_low || (sda_oe && !sda_out));

    mlc_lane_regs #(.DETECT_CYC(DET)) i_mlc_lane_regs (.clk(clk), .arst_n(arst_n), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .rx_present(rx_present),
        .detect_probe(probe), .term_50ohm(term), .short_circuit_prot_en(scp),
        .rate_gen12_sel(gen12), .output_swing_sel(swing), .deemphasis_sel(deemph));
    mlc_host_model i_mlc_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Non-blocking so a read at the same edge always sees the older count
    always @(posedge clk)
        if (probe === 1'b1)
            probe_cnt <= probe_cnt + 1;

    initial
    begin
        repeat (40000) @(posedge clk);
        $display("[FAIL] %0t watchdog expired", $time);
        fails++;
        stop_test;
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t byte %h, expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_count(input int got, input int exp);
        total_checks++;
        if (got != exp)
        begin
            fails++;
            $display("[FAIL] %0t count %0d, expected %0d", $time, got, exp);
        end
    endtask : chk_count

    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        i_mlc_host_model.write_reg(SA, o, d, ok);
    endtask : wr

    task automatic rdc(input logic [7:0] o, input logic [7:0] exp);
        i_mlc_host_model.read_reg(SA, o, rd);
        chk_byte(rd, exp);
    endtask : rdc

    task automatic stop_test;
        if (fails == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    initial
    begin
        arst_n = 1'b0;
        rx_present = 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk_byte({scp, gen12, term, 2'b00, swing}, 8'h85);
        chk_byte({5'h00, deemph}, 8'h02);
        // Whole map at reset, plus an unmapped offset reading zero
        for (int i = 0; i < 8; i++)
            rdc(OFS_TAB[i], RST_TAB[i]);
        // Every swing and de-emphasis code; read-only status bits written as ones
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            sw = {c[0], c[1], 3'b101, c};
            wr(8'h34, sw);
            chk_byte({7'h00, ok}, 8'h01);
            wr(8'h35, {3'b111, 2'b00, c});
            chk_byte({scp, gen12, 3'b101, swing}, sw);
            chk_byte({5'h00, deemph}, {5'h00, c});
            rdc(8'h34, sw);
            rdc(8'h35, {2'b00, c[1], 2'b00, c});
        end
        // Foreign address is refused; unmapped writes are dropped
        i_mlc_host_model.write_reg(SA ^ 7'h01, 8'h34, 8'h00, ok);
        chk_byte({7'h00, ok}, 8'h00);
        wr(8'h37, 8'hff);
        rdc(8'h34, 8'hef);
        rdc(8'h37, 8'h00);
        // Forced termination at once, never probing; then field 00 releases it
        p0 = probe_cnt;
        wr(8'h39, 8'h0c);
        chk_byte({7'h00, term}, 8'h01);
        repeat (3 * DET) @(posedge clk);
        chk_count(probe_cnt - p0, 0);
        wr(8'h39, 8'h00);
        p0 = probe_cnt;
        repeat (3 * DET) @(posedge clk);
        chk_byte({7'h00, term}, 8'h00);
        chk_count(probe_cnt - p0, 0);
        // Limited mode rewritten partway gets a fresh budget of 50 probes
        wr(8'h39, 8'h04);
        repeat (25 * DET) @(posedge clk);
        wr(8'h39, 8'h04);
        p0 = probe_cnt;
        repeat (60 * DET) @(posedge clk);
        chk_count(probe_cnt - p0, 50);
        chk_byte({7'h00, term}, 8'h00);
        // Endless mode goes past 50 probes, then a receiver answers
        wr(8'h39, 8'h08);
        p0 = probe_cnt;
        repeat (70 * DET) @(posedge clk);
        chk_count(int'(probe_cnt - p0 > 50), 1);
        rx_present <= 1'b1;
        repeat (DET + 2) @(posedge clk);
        rx_present <= 1'b0;
        chk_byte({7'h00, term}, 8'h01);
        p0 = probe_cnt;
        rdc(8'h35, 8'ha7);
        chk_count(probe_cnt - p0, 0);
        stop_test;
    end
endmodule : mlc_lane_regs_tb
